// ==== design/vcd_defs.svh ====
// Offsets, encodings and reset values of the virtual deactivate block.
// Assumes byte addressing on a 32-bit Avalon-MM slave, one word per register.
`ifndef VCD_DEFS_SVH
`define VCD_DEFS_SVH

`define VCD_OFF_AHPPIR 12'h028
`define VCD_OFF_APR0 12'h0d0
`define VCD_OFF_APR1 12'h0d4
`define VCD_OFF_APR2 12'h0d8
`define VCD_OFF_APR3 12'h0dc
`define VCD_OFF_NSAPR0 12'h0e0
`define VCD_OFF_NSAPR1 12'h0e4
`define VCD_OFF_NSAPR2 12'h0e8
`define VCD_OFF_NSAPR3 12'h0ec
`define VCD_OFF_IIDR 12'h0fc
`define VCD_OFF_DIR 12'h100
`define VCD_OFF_IRQ_STAT 12'h200
`define VCD_OFF_IRQ_EN 12'h204
`define VCD_OFF_IRQ_CLR 12'h208

`define VCD_ID_SPURIOUS 10'h3ff

`define VCD_LR_INVALID 2'h0
`define VCD_LR_PENDING 2'h1
`define VCD_LR_ACTIVE 2'h2
`define VCD_LR_ACT_PEND 2'h3

`define VCD_EV_W 3
`define VCD_EV_UNMATCHED 0
`define VCD_EV_FORWARD 1
`define VCD_EV_ODD_STATE 2

`define VCD_EV_RESET 3'h0
`define VCD_WORD_RESET 32'h0000_0000

`endif

// ==== design/vcd_pkg.sv ====
// Types shared by the virtual deactivate block and its surroundings.
// Assumes list entries are held outside and presented as packed structs.
package vcd_pkg;

  // One list entry as the hypervisor keeps it.
  typedef struct packed {
    logic hardware_backed_flag;
    logic group_one_flag;
    logic [1:0] state;
    logic [4:0] prio;
    logic [9:0] pid;
    logic [9:0] vid;
  } vcd_lr_t;

  // State change of one list entry requested by a deactivate write.
  typedef struct packed {
    logic valid;
    logic [5:0] index;
    logic [1:0] state;
  } vcd_lr_upd_t;

  // Deactivate request towards the physical distributor.
  typedef struct packed {
    logic valid;
    logic non_secure;
    logic [9:0] pid;
  } vcd_deact_t;

endpackage

// ==== design/vcd_top.sv ====
// Virtual CPU interface slice: aliased highest pending read, active priority
// aliasing, identification and the deactivate path, with an event interrupt.
// Assumes list entries, hypervisor active priority and priority masks come
// from logic on the same clock; update outputs are one-cycle pulses.
`timescale 1ns/1ps
`include "vcd_defs.svh"

// Behaviour
// - Group 0 winner reads as spurious 1023
// - Group 1 winner reads its own ID
// - Nothing signallable reads as spurious 1023
// - Winner drawn from both groups; only group 1 IDs are reported
// - Active-and-pending entries are never reported
// - Priority readback then writeback changes nothing
// - First active-priority word aliases hypervisor register
// - Other active-priority words read zero, ignore writes
// - Non-secure active-priority space reads zero too
// - Read-only implementer and revision identification
// - Deactivate turns active entry invalid
// - Deactivate turns active-pending entry pending
// - Other matched states handled consistently
// - Unmatched deactivate bumps unmatched completion count
// - Hardware-backed active or active-pending match forwards physical ID deactivate
// - Forwarded deactivate is non-secure, distributor filters
// - Group flag selects group 0 or 1
module vcd_top import vcd_pkg::*; #(
  parameter int NUM_LR = 4,
  parameter logic [11:0] IMPLEMENTER = 12'h123, // Arbitrary value.
  parameter logic [3:0] REVISION = 4'h1, // Arbitrary value.
  parameter logic [3:0] ARCH_VER = 4'h1, // Arbitrary value.
  parameter logic [11:0] PRODUCT = 12'h456 // Arbitrary value.
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire vcd_lr_t [NUM_LR-1:0] hyp_list_entry,
  input wire logic [31:0] hyp_active_priority_reg,
  input wire logic vif_enable,
  input wire logic [7:0] pri_mask,
  input wire logic [7:0] running_prio,
  input wire logic split_completion_mode,
  input wire logic ack_group_control,
  output vcd_lr_upd_t lr_update,
  output logic unmatched_completion_inc,
  output vcd_deact_t deact_req,
  output logic hyp_apr_wr,
  output logic [31:0] hyp_apr_wdata,
  output logic irq
);

  // The entry index is six bits wide, so no more than 64 entries are served.
  if (NUM_LR < 1 || NUM_LR > 64) begin : g_bad_num_lr
    $error("NUM_LR must lie between 1 and 64.");
  end

  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic req;
  logic rd_load;
  logic wr_fire;
  logic dir_fire;
  logic [`VCD_EV_W-1:0] stat_q;
  logic [`VCD_EV_W-1:0] en_q;
  logic [`VCD_EV_W-1:0] ev_set;
  logic [`VCD_EV_W-1:0] ev_clr;
  vcd_lr_upd_t lr_update_q;
  vcd_deact_t deact_q;
  logic inc_q;
  logic apr_wr_q;
  logic [31:0] apr_wdata_q;
  logic irq_q;

  // Highest pending search results.
  logic win_valid;
  logic [5:0] win_idx;
  logic [4:0] win_prio;
  logic win_sufficient;
  logic [9:0] hp_id;
  logic [2:0] hp_cpuid;

  // Deactivate match results.
  logic match_found;
  logic [5:0] match_idx;
  vcd_lr_t match_lr;

  // The answer is always one wait cycle; the read word is loaded while the
  // request waits, so it stands on the edge where waitrequest is sampled low.
  assign req = avs_read | avs_write;
  assign rd_load = avs_read & wait_q;
  assign wr_fire = avs_write & ~wait_q;
  assign dir_fire = wr_fire && avs_address == `VCD_OFF_DIR && avs_byteenable[1:0] == 2'b11;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // Search over pending entries only: active-and-pending ones never win and
  // both groups compete, so a group 0 winner masks any group 1 entry behind it.
  always_comb begin
    win_valid = 1'b0;
    win_idx = 6'h0;
    win_prio = 5'h1f;
    for (int i = 0; i < NUM_LR; i++) begin
      if (hyp_list_entry[i].state == `VCD_LR_PENDING &&
          (!win_valid || hyp_list_entry[i].prio < win_prio)) begin
        win_valid = 1'b1;
        win_idx = 6'(i);
        win_prio = hyp_list_entry[i].prio;
      end
    end
  end

  assign win_sufficient = win_valid && vif_enable &&
                          {win_prio, 3'b000} < pri_mask && {win_prio, 3'b000} < running_prio;

  // The acknowledge group control has no say in the aliased view.
  always_comb begin
    hp_id = `VCD_ID_SPURIOUS;
    hp_cpuid = 3'h0;
    if (win_sufficient && hyp_list_entry[win_idx].group_one_flag) begin
      hp_id = hyp_list_entry[win_idx].vid;
      if (!hyp_list_entry[win_idx].hardware_backed_flag) begin
        hp_cpuid = hyp_list_entry[win_idx].pid[2:0];
      end
    end
  end

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    rdata_d = `VCD_WORD_RESET;
    case (avs_address)
      `VCD_OFF_AHPPIR: rdata_d = {19'h0, hp_cpuid, hp_id};
      `VCD_OFF_APR0: rdata_d = hyp_active_priority_reg;
      `VCD_OFF_APR1, `VCD_OFF_APR2, `VCD_OFF_APR3: rdata_d = `VCD_WORD_RESET;
      `VCD_OFF_NSAPR0, `VCD_OFF_NSAPR1, `VCD_OFF_NSAPR2, `VCD_OFF_NSAPR3: begin
        rdata_d = `VCD_WORD_RESET;
      end
      `VCD_OFF_IIDR: rdata_d = {PRODUCT, ARCH_VER, REVISION, IMPLEMENTER};
      `VCD_OFF_IRQ_STAT: rdata_d = {29'h0, stat_q};
      `VCD_OFF_IRQ_EN: rdata_d = {29'h0, en_q};
      default: rdata_d = `VCD_WORD_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= `VCD_WORD_RESET;
    end else if (rd_load) begin
      rdata_q <= rdata_d;
    end
  end

  // Writing back what was read drives the same word into the hypervisor
  // register, so state is left as it was; other priority words drop writes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      apr_wr_q <= 1'b0;
      apr_wdata_q <= `VCD_WORD_RESET;
    end else begin
      apr_wr_q <= wr_fire && avs_address == `VCD_OFF_APR0;
      if (wr_fire && avs_address == `VCD_OFF_APR0) begin
        apr_wdata_q <= merge_lanes(hyp_active_priority_reg, avs_writedata, avs_byteenable);
      end
    end
  end

  // First valid entry whose virtual ID equals the written ID.
  always_comb begin
    match_found = 1'b0;
    match_idx = 6'h0;
    for (int i = 0; i < NUM_LR; i++) begin
      if (!match_found && hyp_list_entry[i].state != `VCD_LR_INVALID &&
          hyp_list_entry[i].vid == avs_writedata[9:0]) begin
        match_found = 1'b1;
        match_idx = 6'(i);
      end
    end
  end

  assign match_lr = hyp_list_entry[match_idx];

  // Writes outside split completion mode are dropped and flagged; software
  // must not make them, so this is only a safe landing.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lr_update_q <= '0;
      inc_q <= 1'b0;
      deact_q <= '0;
    end else begin
      lr_update_q.valid <= 1'b0;
      inc_q <= 1'b0;
      deact_q.valid <= 1'b0;
      if (dir_fire && split_completion_mode) begin
        if (!match_found) begin
          inc_q <= 1'b1;
        end else begin
          lr_update_q.index <= match_idx;
          if (match_lr.state == `VCD_LR_ACTIVE) begin
            lr_update_q.valid <= 1'b1;
            lr_update_q.state <= `VCD_LR_INVALID;
          end else if (match_lr.state == `VCD_LR_ACT_PEND) begin
            lr_update_q.valid <= 1'b1;
            lr_update_q.state <= `VCD_LR_PENDING;
          end
          // A pending-only match changes no entry and forwards nothing.
          if (match_lr.hardware_backed_flag && match_lr.state[1]) begin
            deact_q.valid <= 1'b1;
            deact_q.non_secure <= 1'b1;
            deact_q.pid <= match_lr.pid;
          end
        end
      end
    end
  end

  always_comb begin
    ev_set = `VCD_EV_RESET;
    if (dir_fire) begin
      ev_set[`VCD_EV_UNMATCHED] = split_completion_mode & ~match_found;
      ev_set[`VCD_EV_FORWARD] = split_completion_mode & match_found &
                                match_lr.hardware_backed_flag & match_lr.state[1];
      ev_set[`VCD_EV_ODD_STATE] = ~split_completion_mode |
                                  (match_found & ~match_lr.state[1]);
    end
  end

  always_comb begin
    ev_clr = `VCD_EV_RESET;
    if (wr_fire && avs_address == `VCD_OFF_IRQ_CLR) begin
      ev_clr = avs_writedata[`VCD_EV_W-1:0];
    end
  end

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= `VCD_EV_RESET;
    end else begin
      stat_q <= (stat_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_q <= `VCD_EV_RESET;
    end else if (wr_fire && avs_address == `VCD_OFF_IRQ_EN && avs_byteenable[0]) begin
      en_q <= avs_writedata[`VCD_EV_W-1:0];
    end
  end

  // Registered from the next status so the line follows the bits at once.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((stat_q & ~ev_clr) | ev_set) & en_q);
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
  assign lr_update = lr_update_q;
  assign unmatched_completion_inc = inc_q;
  assign deact_req = deact_q;
  assign hyp_apr_wr = apr_wr_q;
  assign hyp_apr_wdata = apr_wdata_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic hp_rd;
  assign hp_rd = rd_load && avs_address == `VCD_OFF_AHPPIR;

  a_hp_group0_spur: assert property (
    hp_rd && win_sufficient && !hyp_list_entry[win_idx].group_one_flag
    |=> avs_readdata[9:0] == `VCD_ID_SPURIOUS && !avs_waitrequest)
    else $error("Group 0 winner did not read as spurious.");

  a_hp_group1_id: assert property (
    hp_rd && win_sufficient && hyp_list_entry[win_idx].group_one_flag
    |=> avs_readdata[9:0] == $past(hyp_list_entry[win_idx].vid))
    else $error("Group 1 winner ID not returned.");

  a_hp_none_spur: assert property (
    hp_rd && !win_sufficient |=> avs_readdata[9:0] == `VCD_ID_SPURIOUS)
    else $error("No signallable interrupt but ID not spurious.");

  a_hp_only_pend: assert property (
    win_valid |-> hyp_list_entry[win_idx].state == `VCD_LR_PENDING)
    else $error("Winner is not a pending-only entry.");

  a_apr0_alias_rd: assert property (
    rd_load && avs_address == `VCD_OFF_APR0
    |=> avs_readdata == $past(hyp_active_priority_reg))
    else $error("Active priority word 0 is not the alias.");

  a_apr_raz_rd: assert property (
    rd_load && avs_address >= `VCD_OFF_APR1 && avs_address <= `VCD_OFF_NSAPR3
    |=> avs_readdata == `VCD_WORD_RESET ##1 !hyp_apr_wr)
    else $error("Zero-read priority space returned data.");

  a_ident_value: assert property (
    rd_load && avs_address == `VCD_OFF_IIDR
    |=> avs_readdata == {PRODUCT, ARCH_VER, REVISION, IMPLEMENTER})
    else $error("Identification word wrong.");

  a_deact_active: assert property (
    dir_fire && split_completion_mode && match_found && match_lr.state == `VCD_LR_ACTIVE
    |=> lr_update.valid && lr_update.state == `VCD_LR_INVALID
        && lr_update.index == $past(match_idx) ##1 !lr_update.valid)
    else $error("Active entry not made invalid.");

  a_deact_actpend: assert property (
    dir_fire && split_completion_mode && match_found && match_lr.state == `VCD_LR_ACT_PEND
    |=> lr_update.valid && lr_update.state == `VCD_LR_PENDING)
    else $error("Active-pending entry not made pending.");

  a_unmatched_count: assert property (
    dir_fire && split_completion_mode && !match_found
    |=> unmatched_completion_inc && !lr_update.valid ##1 !unmatched_completion_inc)
    else $error("Unmatched deactivate did not count once.");

  a_forward_phys: assert property (
    dir_fire && split_completion_mode && match_found && match_lr.hardware_backed_flag
    && match_lr.state[1]
    |=> deact_req.valid && deact_req.non_secure && deact_req.pid == $past(match_lr.pid))
    else $error("Hardware-backed deactivate not forwarded.");

  a_irq_level: assert property (
    $rose(stat_q[`VCD_EV_UNMATCHED]) && en_q[`VCD_EV_UNMATCHED] |-> irq)
    else $error("Enabled event did not raise the interrupt.");

  a_apr_wr_ignore: assert property (
    wr_fire && avs_address >= `VCD_OFF_APR1 && avs_address <= `VCD_OFF_NSAPR3
    |=> !hyp_apr_wr)
    else $error("Write to a zero-read priority word reached the hypervisor.");

  a_apr0_wr_alias: assert property (
    wr_fire && avs_address == `VCD_OFF_APR0 && avs_byteenable == 4'hf
    |=> hyp_apr_wr && hyp_apr_wdata == $past(avs_writedata))
    else $error("Active priority word 0 write not passed on unchanged.");

  a_mode0_inert: assert property (
    dir_fire && !split_completion_mode
    |=> !lr_update.valid && !deact_req.valid && !unmatched_completion_inc)
    else $error("Deactivate outside split mode changed state.");

  c_hp_group1: cover property (hp_rd && win_sufficient && hyp_list_entry[win_idx].group_one_flag);
  c_hp_group0: cover property (hp_rd && win_sufficient && !hyp_list_entry[win_idx].group_one_flag);
  c_forward: cover property (deact_req.valid);
  c_unmatched_irq: cover property (unmatched_completion_inc ##1 irq);

endmodule

// ==== verif/vcd_dist_model.sv ====
// Behavioural model of the physical distributor that takes deactivate requests.
// Assumes deact_req is a registered one-cycle pulse on clk.
`timescale 1ns/1ps
module vcd_dist_model import vcd_pkg::*; #(
  parameter logic [9:0] GRP0_PID = 10'h3e0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire vcd_deact_t deact_req,
  output int fwd_cnt,
  output int drop_cnt,
  output logic [9:0] last_pid
);
  // A secure request would reach group 0 too, so a wrong security flag shows as a forward.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fwd_cnt <= 0;
      drop_cnt <= 0;
      last_pid <= 10'h000;
    end else if (deact_req.valid === 1'b1) begin
      if (deact_req.non_secure === 1'b1 && deact_req.pid == GRP0_PID) begin
        drop_cnt <= drop_cnt + 1;
      end else begin
        fwd_cnt <= fwd_cnt + 1;
        last_pid <= deact_req.pid;
      end
    end
  end
endmodule

// ==== verif/vcd_top_bench.sv ====
// Self-checking bench for the virtual deactivate block.
// Assumes one 50 MHz clock; list entries are held here in place of the hypervisor.
`timescale 1ns/1ps
`include "vcd_defs.svh"
module vcd_top_bench import vcd_pkg::*;;
  localparam logic [11:0] IMPL = 12'h0ab; // Arbitrary value.
  localparam logic [11:0] PROD = 12'h0cd; // Arbitrary value.
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  vcd_lr_t [3:0] lr = '0;
  logic [31:0] hyp_apr = 32'h8000_0001;
  logic [7:0] pri_mask = 8'hff;
  logic vif_en = 1'b1;
  logic [7:0] run_prio = 8'hff;
  logic split = 1'b1;
  logic ack_ctl = 1'b0;
  vcd_lr_upd_t lr_update, upd_seen;
  vcd_deact_t deact_req;
  logic inc, apr_wr, irq;
  logic [31:0] apr_wdata, apr_seen, q;
  logic [9:0] last_pid;
  int fwd_cnt, drop_cnt, upd_n, inc_n;
  int error_cnt = 0;
  int compares = 0;

  always #10 clk = ~clk;

  vcd_top #(.NUM_LR(4), .IMPLEMENTER(IMPL), .REVISION(4'h2), .ARCH_VER(4'h3),
    .PRODUCT(PROD)) u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hyp_list_entry(lr), .hyp_active_priority_reg(hyp_apr), .vif_enable(vif_en),
    .pri_mask(pri_mask), .running_prio(run_prio), .split_completion_mode(split),
    .ack_group_control(ack_ctl), .lr_update(lr_update), .unmatched_completion_inc(inc),
    .deact_req(deact_req), .hyp_apr_wr(apr_wr), .hyp_apr_wdata(apr_wdata), .irq(irq));

  vcd_dist_model u_dist (.clk(clk), .nrst(nrst), .deact_req(deact_req),
    .fwd_cnt(fwd_cnt), .drop_cnt(drop_cnt), .last_pid(last_pid));

  // Pulses last one cycle, so they are latched here for the scenarios to judge later.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upd_n <= 0;
      inc_n <= 0;
      apr_seen <= 32'h0000_0000;
    end else begin
      if (lr_update.valid === 1'b1) begin
        upd_n <= upd_n + 1;
        upd_seen <= lr_update;
      end
      if (inc === 1'b1) inc_n <= inc_n + 1;
      if (apr_wr === 1'b1) apr_seen <= apr_wdata;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function automatic vcd_lr_t ent(logic hw, logic g1, logic [1:0] st, logic [4:0] p,
    logic [9:0] pid, logic [9:0] vid);
    return '{hw, g1, st, p, pid, vid};
  endfunction

  task automatic t_pending();
    for (int k = 0; k < 2; k++) begin
      ack_ctl <= k[0];
      pri_mask <= 8'hff;
      // The second pass makes the winner software-generated, so its source shows.
      lr[0] <= ent(~k[0], 1, `VCD_LR_PENDING, 5'd4, 10'h005, 10'd20);
      lr[1] <= ent(1, 1, `VCD_LR_ACT_PEND, 5'd1, 10'h0, 10'd21);
      lr[2] <= ent(1, 0, `VCD_LR_PENDING, 5'd8, 10'h0, 10'd22);
      lr[3] <= '0;
      bus(0, `VCD_OFF_AHPPIR, 0);
      chk(q, {19'h0, (k[0] ? 3'h5 : 3'h0), 10'd20});
      lr[2].prio <= 5'd2;
      bus(0, `VCD_OFF_AHPPIR, 0);
      chk(q, 32'h0000_03ff);
      lr[2].prio <= 5'd8;
      pri_mask <= 8'h20;
      bus(0, `VCD_OFF_AHPPIR, 0);
      chk(q, 32'h0000_03ff);
    end
    pri_mask <= 8'hff;
    vif_en <= 1'b0;
    bus(0, `VCD_OFF_AHPPIR, 0);
    chk(q, 32'h0000_03ff);
    vif_en <= 1'b1;
    run_prio <= 8'h20;
    bus(0, `VCD_OFF_AHPPIR, 0);
    chk(q, 32'h0000_03ff);
    run_prio <= 8'hff;
  endtask

  task automatic t_apr_id();
    bus(0, `VCD_OFF_APR0, 0);
    chk(q, 32'h8000_0001);
    bus(1, `VCD_OFF_APR0, q);
    repeat (2) @(posedge clk);
    chk(apr_seen, 32'h8000_0001);
    for (int i = 1; i < 8; i++) begin
      bus(1, 12'h0d0 + 12'(4 * i), 32'hffff_ffff);
      bus(0, 12'h0d0 + 12'(4 * i), 0);
      chk(q, 32'h0);
    end
    chk(apr_seen, 32'h8000_0001);
    bus(1, `VCD_OFF_IIDR, 32'h0);
    bus(0, `VCD_OFF_IIDR, 0);
    chk(q, {PROD, 4'h3, 4'h2, IMPL});
    bus(0, 12'h300, 0);
    chk(q, 32'h0);
  endtask

  task automatic dir(input logic [9:0] id);
    bus(1, `VCD_OFF_DIR, {22'h0, id});
    repeat (3) @(posedge clk);
  endtask

  task automatic t_deact();
    pri_mask <= 8'hff;
    lr[0] <= ent(1, 1, `VCD_LR_ACTIVE, 5'd0, 10'h021, 10'd5);
    lr[1] <= ent(0, 1, `VCD_LR_ACT_PEND, 5'd0, 10'h003, 10'd6);
    lr[2] <= ent(1, 1, `VCD_LR_PENDING, 5'd0, 10'h007, 10'd7);
    lr[3] <= ent(1, 1, `VCD_LR_INVALID, 5'd0, 10'h009, 10'd9);
    bus(1, `VCD_OFF_IRQ_EN, 32'h7);
    dir(10'd5);
    chk({upd_seen, 23'h0}, {1'b1, 6'd0, `VCD_LR_INVALID, 23'h0});
    chk({fwd_cnt[7:0], 14'h0, last_pid}, {8'd1, 14'h0, 10'h021});
    dir(10'd6);
    chk({upd_seen, 23'h0}, {1'b1, 6'd1, `VCD_LR_PENDING, 23'h0});
    chk(fwd_cnt, 1);
    dir(10'd9);
    chk(inc_n, 1);
    dir(10'd7);
    chk(upd_n, 2);
    chk(fwd_cnt, 1);
    bus(0, `VCD_OFF_IRQ_STAT, 0);
    chk(q, 32'h7);
    chk({31'h0, irq}, 32'h1);
    bus(1, `VCD_OFF_IRQ_CLR, 32'h3);
    bus(0, `VCD_OFF_IRQ_STAT, 0);
    chk(q, 32'h4);
    chk({31'h0, irq}, 32'h1);
    bus(1, `VCD_OFF_IRQ_EN, 32'h3);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    lr[0].pid <= u_dist.GRP0_PID;
    dir(10'd5);
    chk(drop_cnt, 1);
    chk(fwd_cnt, 1);
    // Guest writes outside split mode are refused and only flagged.
    split <= 1'b0;
    bus(1, `VCD_OFF_IRQ_CLR, 32'h7);
    dir(10'd5);
    chk(upd_n, 3);
    chk(drop_cnt, 1);
    bus(0, `VCD_OFF_IRQ_STAT, 0);
    chk(q, 32'h4);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    chk({31'h0, avs_waitrequest}, 32'h1);
    nrst <= 1'b1;
    bus(0, `VCD_OFF_IRQ_STAT, 0);
    chk(q, 32'h0);
    chk({31'h0, irq}, 32'h0);
    t_pending();
    t_apr_id();
    t_deact();
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule
